// ===== flash_guard_pkg.sv
package flash_guard_pkg;

	// ---------------------------------------------------------------
	// protection address layout
	// ---------------------------------------------------------------
	localparam int addr_width = 16;
	localparam int start_bits_lsb = 6;
	localparam int start_bits_msb = 13;
	localparam logic [1:0] start_top_bits = 2'h3;
	localparam logic [5:0] start_low_bits = 6'h00;
	localparam logic [7:0] boundary_all_open = 8'hff;
	localparam logic [7:0] boundary_all_closed = 8'h00;
	localparam logic [7:0] boundary_vectors_only = 8'hfe;
	localparam logic [7:0] boundary_reset_value = 8'hff;
	localparam logic [15:0] boundary_byte_addr = 16'hff7e;

	// sequencer states
	typedef enum logic [1:0] {seq_read, seq_armed, seq_high_voltage, seq_standby} seq_state_type;

	// flash control signals carried together
	typedef struct packed {
		logic program_select;
		logic erase_select;
		logic mass_select;
		logic high_voltage_enable;
	} flash_ctrl_type;

endpackage

// ===== flash_block_protect_guard.sv
module flash_block_protect_guard
	import flash_guard_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic program_select,
	input wire logic erase_select,
	input wire logic mass_select,
	input wire logic high_voltage_request,
	input wire logic clear_request,
	input wire logic array_write,
	input wire logic [15:0] array_addr,
	input wire logic [7:0] array_wdata,
	input wire logic wait_mode,
	input wire logic stop_mode,
	input wire logic test_voltage_pin,
	output logic [7:0] protect_boundary,
	output logic [15:0] protect_start,
	output logic target_protected,
	output logic high_voltage_refused,
	output flash_ctrl_type flash_ctrl,
	output logic flash_standby
);

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic tst_meta_q, tst_sync_q;
	logic wait_meta_q, wait_sync_q;
	logic stop_meta_q, stop_sync_q;

	// two-flop capture of pin-level inputs
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			{tst_meta_q, tst_sync_q} <= 2'h0;
			{wait_meta_q, wait_sync_q} <= 2'h0;
			{stop_meta_q, stop_sync_q} <= 2'h0;
		end
		else
		begin
			tst_meta_q <= test_voltage_pin;
			tst_sync_q <= tst_meta_q;
			wait_meta_q <= wait_mode;
			wait_sync_q <= wait_meta_q;
			stop_meta_q <= stop_mode;
			stop_sync_q <= stop_meta_q;
		end
	end

	// ---------------------------------------------------------------
	// start address
	// ---------------------------------------------------------------
	function automatic logic [15:0] start_of(input logic [7:0] bits);
		start_of = {start_top_bits, bits, start_low_bits};
	endfunction

	function automatic logic covers(input logic [7:0] bits, input logic [15:0] addr);
		// 00 protects all; ff protects none; else compare
		if (bits == boundary_all_closed)
			covers = 1'b1;
		else if (bits == boundary_all_open)
			covers = 1'b0;
		else
			covers = addr >= start_of(bits);
	endfunction

	// ---------------------------------------------------------------
	// sequencer
	// ---------------------------------------------------------------
	seq_state_type state_q, state_d;
	logic [7:0] boundary_q;
	logic [addr_width-1:0] target_q;
	logic refused_q;
	flash_ctrl_type ctrl_q, ctrl_d;

	// operation and low-power decode
	wire active_op = program_select || erase_select;
	wire in_operation = state_q == seq_armed || state_q == seq_high_voltage;
	wire low_power = wait_sync_q || stop_sync_q;
	wire abort_op = in_operation && low_power;
	wire start_op = state_q == seq_read && active_op && array_write;

	// protection decode; the test voltage overrides every refusal
	wire bypass = tst_sync_q;
	wire locked = boundary_q != boundary_all_open && boundary_q != boundary_vectors_only;
	wire target_is_boundary = target_q == boundary_byte_addr;
	wire mass_blocked = mass_select && erase_select && boundary_q != boundary_all_open;
	wire region_hit = covers(boundary_q, target_q) || (locked && target_is_boundary);
	wire deny = !bypass && (region_hit || mass_blocked);
	wire refuse_now = state_q == seq_armed && high_voltage_request && deny;

	// only a program write under high voltage to the latched boundary byte lands
	wire commit = state_q == seq_high_voltage && program_select && array_write
		&& target_is_boundary;

	assign protect_boundary = boundary_q;
	assign protect_start = start_of(boundary_q);
	assign target_protected = region_hit;
	assign high_voltage_refused = refused_q;
	assign flash_ctrl = ctrl_q;
	assign flash_standby = state_q == seq_standby;

	// next state; wait in read mode simply stays in read
	always_comb
	begin
		state_d = state_q;
		ctrl_d = ctrl_q;
		unique case (state_q)
			seq_read:
			begin
				ctrl_d = '0;
				if (active_op && array_write)
				begin
					state_d = seq_armed;
					ctrl_d.program_select = program_select;
					ctrl_d.erase_select = erase_select;
					ctrl_d.mass_select = mass_select;
				end
			end
			seq_armed:
			begin
				if (abort_op)
					state_d = seq_standby;
				else if (high_voltage_request && !deny)
				begin
					state_d = seq_high_voltage;
					ctrl_d.high_voltage_enable = 1'b1;
				end
				else if (clear_request || !active_op)
				begin
					state_d = seq_read;
					ctrl_d = '0;
				end
			end
			seq_high_voltage:
			begin
				if (abort_op)
					state_d = seq_standby;
				else if (clear_request)
				begin
					state_d = seq_read;
					ctrl_d = '0;
				end
			end
			seq_standby:
			begin
				ctrl_d = '0;
				if (!low_power && !active_op)
					state_d = seq_read;
			end
		endcase
		if (state_d == seq_standby)
			ctrl_d = '0;
	end

	// sequencer state and flash controls
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			state_q <= seq_read;
			ctrl_q <= '0;
		end
		else
		begin
			state_q <= state_d;
			ctrl_q <= ctrl_d;
		end
	end

	// target address, latched by the write that starts an operation
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			target_q <= '0;
		else if (start_op)
			target_q <= array_addr;
	end

	// boundary byte; programming can only clear bits, as in the array
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			boundary_q <= boundary_reset_value;
		else if (commit)
			boundary_q <= boundary_q & array_wdata;
	end

	// refusal flag, high the cycle after each armed cycle in which a request is refused
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			refused_q <= 1'b0;
		else
			refused_q <= refuse_now;
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	// a high voltage request that the sequencer will act on
	sequence hv_attempt_s;
		state_q == seq_armed && high_voltage_request && !low_power;
	endsequence

	// an operation under way meets wait or stop
	sequence abort_entry_s;
		in_operation && low_power;
	endsequence

	// standby reached with every flash control dropped
	sequence standby_quiet_s;
		flash_standby && flash_ctrl == '0;
	endsequence

	// start address shape and fixed bits

	start_layout_a: assert property (@(posedge clk) disable iff (!reset_n)
		protect_start[15:14] == start_top_bits && protect_start[5:0] == start_low_bits)
		else $error("start address fixed bits wrong");
	start_map_a: assert property (@(posedge clk) disable iff (!reset_n)
		protect_start[start_bits_msb:start_bits_lsb] == protect_boundary)
		else $error("start address does not follow boundary");

	// protected range and refusals
	whole_array_a: assert property (@(posedge clk) disable iff (!reset_n)
		protect_boundary == boundary_all_closed |-> target_protected)
		else $error("zero boundary left target open");
	open_array_a: assert property (@(posedge clk) disable iff (!reset_n)
		protect_boundary == boundary_all_open && target_q != boundary_byte_addr
		|-> !target_protected)
		else $error("erased boundary protected target");
	hv_refused_a: assert property (@(posedge clk) disable iff (!reset_n)
		hv_attempt_s ##0 (target_protected && !tst_sync_q) |=>
		!flash_ctrl.high_voltage_enable && high_voltage_refused)
		else $error("high voltage set on protected target");
	mass_block_a: assert property (@(posedge clk) disable iff (!reset_n)
		hv_attempt_s ##0 (mass_blocked && !tst_sync_q) |=> !flash_ctrl.high_voltage_enable)
		else $error("mass erase allowed with protection");

	// low power aborts, the standby state, the test voltage bypass and boundary stability
	abort_standby_a: assert property (@(posedge clk) disable iff (!reset_n)
		abort_entry_s |=> standby_quiet_s)
		else $error("low power did not abort to standby");
	standby_quiet_a: assert property (@(posedge clk) disable iff (!reset_n)
		flash_standby |-> flash_ctrl == '0)
		else $error("control active in standby");
	bypass_a: assert property (@(posedge clk) disable iff (!reset_n)
		hv_attempt_s ##0 tst_sync_q |=> flash_ctrl.high_voltage_enable)
		else $error("test voltage did not bypass protection");
	boundary_stable_a: assert property (@(posedge clk) disable iff (!reset_n)
		!commit |=> $stable(protect_boundary))
		else $error("boundary changed outside programming");

	// page alignment and the vector starts
	page_boundary_a: assert property (@(posedge clk) disable iff (!reset_n)
		protect_start[7:0] inside {8'h00, 8'h40, 8'h80, 8'hc0})
		else $error("start address off a page boundary");
	fd_start_a: assert property (@(posedge clk) disable iff (!reset_n)
		protect_boundary == 8'hfd |-> protect_start == 16'hff40)
		else $error("fd boundary start wrong");
	fe_start_a: assert property (@(posedge clk) disable iff (!reset_n)
		protect_boundary == boundary_vectors_only |-> protect_start == 16'hff80)
		else $error("fe boundary start wrong");

	// operation bookkeeping
	target_latch_a: assert property (@(posedge clk) disable iff (!reset_n)
		state_q == seq_read && active_op && array_write |=> target_q == $past(array_addr))
		else $error("target address not latched");
	boundary_write_a: assert property (@(posedge clk) disable iff (!reset_n)
		commit |=> protect_boundary == ($past(protect_boundary) & $past(array_wdata)))
		else $error("boundary programming did not land");
	refused_quiet_a: assert property (@(posedge clk) disable iff (!reset_n)
		high_voltage_refused |-> !flash_ctrl.high_voltage_enable)
		else $error("high voltage on with a refusal");
	boundary_lock_a: assert property (@(posedge clk) disable iff (!reset_n)
		hv_attempt_s ##0 (locked && target_is_boundary && !tst_sync_q)
		|=> !flash_ctrl.high_voltage_enable)
		else $error("locked boundary byte opened to high voltage");

	// read mode and standby under low power
	wait_read_a: assert property (@(posedge clk) disable iff (!reset_n)
		state_q == seq_read && low_power |=> !flash_standby)
		else $error("low power in read mode left read");
	stop_abort_a: assert property (@(posedge clk) disable iff (!reset_n)
		in_operation && stop_sync_q |=> flash_standby)
		else $error("stop did not abort to standby");
	standby_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
		flash_standby && (low_power || active_op) |=> flash_standby)
		else $error("standby left too early");

endmodule // flash_block_protect_guard

// ===== flash_block_protect_guard_bench.sv
module flash_block_protect_guard_bench
	import flash_guard_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// signals and design
	// ----------------------------------------
	logic clk = 1'b0;
	logic reset_n, program_select, erase_select, mass_select, high_voltage_request;
	logic clear_request, array_write, wait_mode, stop_mode, test_voltage_pin;
	logic [15:0] array_addr;
	logic [7:0] array_wdata;
	logic [7:0] protect_boundary;
	logic [15:0] protect_start;
	logic target_protected, high_voltage_refused, flash_standby;
	flash_ctrl_type flash_ctrl;
	int bad_count = 0;
	int n_compared = 0;
	logic [31:0] seed = 32'h2d1cb7ff;
	logic [7:0] v;
	logic [15:0] a;
	logic [7:0] corner [6] = '{8'h00, 8'h01, 8'hfc, 8'hfd, 8'hfe, 8'hff};

	// bus clock, 10 ns period
	always #5 clk = ~clk;

	flash_block_protect_guard dut_u (.clk, .reset_n, .program_select, .erase_select,
		.mass_select, .high_voltage_request, .clear_request, .array_write, .array_addr,
		.array_wdata, .wait_mode, .stop_mode, .test_voltage_pin, .protect_boundary,
		.protect_start, .target_protected, .high_voltage_refused, .flash_ctrl, .flash_standby);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	// expected start and protection of a target
	function automatic logic [15:0] exp_start(input logic [7:0] b);
		return {2'h3, b, 6'h00};
	endfunction
	function automatic logic exp_prot(input logic [7:0] b, input logic [15:0] ad);
		return (b == 8'h00) || (b != 8'hff && ad >= exp_start(b));
	endfunction

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic do_reset();
		@(negedge clk);
		reset_n = 1'b0;
		repeat (5) @(negedge clk);
		reset_n = 1'b1;
		check("boundary reset", 16'h00ff, protect_boundary);
		check("start reset", 16'hffc0, protect_start);
		check("ctrl reset", 16'h0, flash_ctrl);
	endtask

	// one operation: arm, ask for high voltage, write data, clear
	task automatic op(input logic [15:0] ad, input logic [7:0] d, input logic er,
		input logic ms, input logic refuse, input logic tg);
		@(negedge clk);
		{program_select, erase_select, mass_select} = {!er, er, ms};
		array_addr = ad;
		array_wdata = d;
		array_write = 1'b1;
		@(negedge clk);
		array_write = 1'b0;
		high_voltage_request = 1'b1;
		if (!ms) check("target", tg, target_protected);
		check("selects", {!er, er, ms, 1'b0}, flash_ctrl);
		@(negedge clk);
		high_voltage_request = 1'b0;
		check("refused", refuse, high_voltage_refused);
		check("high voltage", !refuse, flash_ctrl.high_voltage_enable);
		array_write = 1'b1;
		@(negedge clk);
		array_write = 1'b0;
		clear_request = 1'b1;
		@(negedge clk);
		{clear_request, program_select, erase_select, mass_select} = 4'h0;
		@(negedge clk);
	endtask

	// abort a live operation by wait or stop
	task automatic low_power(input logic st);
		op(16'hc000, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
		{program_select, array_write, high_voltage_request} = 3'h6;
		@(negedge clk);
		{array_write, high_voltage_request} = 2'h1;
		@(negedge clk);
		{high_voltage_request, wait_mode, stop_mode} = {1'b0, !st, st};
		for (int n = 0; n < 8 && flash_standby !== 1'b1; n++)
			@(negedge clk);
		check("standby", 1'b1, flash_standby);
		check("ctrl idle", 16'h0, flash_ctrl);
		{wait_mode, stop_mode, program_select} = 3'h0;
		repeat (4) @(negedge clk);
		check("standby left", 1'b0, flash_standby);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		{reset_n, program_select, erase_select, mass_select, high_voltage_request} = 5'h0;
		{clear_request, array_write, wait_mode, stop_mode, test_voltage_pin} = 5'h0;
		{array_addr, array_wdata} = 24'h0;
		for (int i = 0; i < 24; i++)
		begin
			seed = xs(seed);
			v = (i < 6) ? corner[i] : seed[7:0];
			a = {2'h3, seed[21:8]};
			do_reset();
			{array_addr, array_wdata, array_write} = {16'hff7e, 8'h00, 1'b1};
			@(negedge clk);
			array_write = 1'b0;
			check("stray write", 16'h00ff, protect_boundary);
			op(16'hff7e, v, 1'b0, 1'b0, 1'b0, 1'b0);
			check("boundary", v, protect_boundary);
			check("start", exp_start(v), protect_start);
			op(a, 8'h55, i[0], 1'b0, exp_prot(v, a), exp_prot(v, a));
			op(16'hc000, 8'h00, 1'b1, 1'b1, v != 8'hff, 1'b0);
			op(16'hff7e, 8'h00, 1'b0, 1'b0, v != 8'hff && v != 8'hfe,
				exp_prot(v, 16'hff7e));
			check("locked", (v == 8'hff || v == 8'hfe) ? 8'h00 : v, protect_boundary);
			$display("test %0d boundary %h done", i, v);
		end
		do_reset();
		wait_mode = 1'b1;
		repeat (4) @(negedge clk);
		check("wait in read", 1'b0, flash_standby);
		wait_mode = 1'b0;
		low_power(1'b0);
		low_power(1'b1);
		$display("test low power done");
		op(16'hff7e, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
		test_voltage_pin = 1'b1;
		repeat (3) @(negedge clk);
		op(16'hc000, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1);
		op(16'hc000, 8'h00, 1'b1, 1'b1, 1'b0, 1'b0);
		$display("test bypass done");
		end_sim();
	end

	// cut a hang short
	initial
	begin
		repeat (100000) @(posedge clk);
		bad_count++;
		end_sim();
	end

endmodule // flash_block_protect_guard_bench
